// ===== common/pwm_unit_pkg.sv
package pwm_unit_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODULATOR_CONTROL = 8'ha1;
  localparam logic [7:0] ADDR_DUTY_CH0 = 8'ha2;
  localparam logic [7:0] ADDR_DUTY_CH1 = 8'ha3;
  localparam logic [7:0] ADDR_DUTY_CH2 = 8'ha4;
  localparam logic [7:0] ADDR_DUTY_CH3 = 8'ha5;
  localparam logic [7:0] ADDR_FIFTH_PERIOD = 8'haa;
  localparam logic [7:0] ADDR_FIFTH_PULSE_WIDTH = 8'hab;
  localparam logic [7:0] ADDR_GROUP_DIVISOR_LOW = 8'hb1;
  localparam logic [7:0] ADDR_GROUP_DIVISOR_HIGH = 8'hb2;
  localparam logic [7:0] ADDR_FIFTH_DIVISOR_LOW = 8'hb3;
  localparam logic [7:0] ADDR_FIFTH_DIVISOR_HIGH = 8'hb4;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int BIT_GROUP_POLARITY = 7;
  localparam int BIT_FIFTH_POLARITY = 6;
  localparam int BIT_MODULATOR_ENABLE = 5;
  localparam int BIT_FIFTH_DRIVE_TYPE = 4;
  localparam int BIT_GROUP_DRIVE_LSB = 0;
  localparam logic [7:0] RESET_REG = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Timing: the unit ticks at half the system clock.
  // ----------------------------------------------------------------
  localparam int HALF_CLOCK_DIVIDE = 2;

  // ----------------------------------------------------------------
  // Bus carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef enum logic [0:0] {
    FIFTH_IDLE,
    FIFTH_RUN
  } fifth_state_t;

endpackage

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  import pwm_unit_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  bus_req_t busReq = '0;
  logic [7:0] rdata;
  logic [3:0] groupOut;
  logic [3:0] groupOe;
  logic fifthOut;
  logic fifthOe;
  logic rdPend = 1'b0;
  logic [7:0] expQ[$];
  logic [31:0] rng = 32'd84258;
  logic [15:0] hiCnt[5];
  logic [15:0] oeCnt[5];
  logic [7:0] regAddr[11];
  int err_count = 0;
  int total_checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  dual_prescaled_pwm_unit dual_prescaled_pwm_unit_i (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .busReq(busReq),
    .rdata(rdata),
    .groupOut(groupOut),
    .groupOe(groupOe),
    .fifthOut(fifthOut),
    .fifthOe(fifthOe)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] nextRand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    busReq <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    @(posedge ref_clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    busReq <= '0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample at that mid-cycle.
  always @(posedge ref_clk) rdPend <= busReq.rd;
  always @(negedge ref_clk) begin
    if (rdPend && expQ.size() > 0) chk({8'h00, rdata}, {8'h00, expQ.pop_front()});
  end

  // Counting high cycles over whole periods makes the result independent of phase.
  task automatic meas(input logic [15:0] n);
    for (int c = 0; c < 5; c++) begin
      hiCnt[c] = '0;
      oeCnt[c] = '0;
    end
    repeat (n) begin
      @(negedge ref_clk);
      for (int c = 0; c < 4; c++) begin
        hiCnt[c] += 16'(groupOut[c]);
        oeCnt[c] += 16'(groupOe[c]);
      end
      hiCnt[4] += 16'(fifthOut);
      oeCnt[4] += 16'(fifthOe);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic grpTest(input logic [7:0] div, input logic pol);
    logic [7:0] d[4];
    logic [15:0] w;
    logic [15:0] h;
    d[0] = 8'h00;
    d[1] = 8'hff;
    d[2] = 8'h01 + (nextRand() % 8'hfe);
    d[3] = 8'h01 + (nextRand() % 8'hfe);
    wr(ADDR_GROUP_DIVISOR_LOW, div);
    for (int c = 0; c < 4; c++) wr(ADDR_DUTY_CH0 + 8'(c), d[c]);
    wr(ADDR_MODULATOR_CONTROL, {pol, 1'b0, 1'b1, 1'b0, 4'b1100});
    repeat (64) @(posedge ref_clk);
    w = 16'd512 * (16'(div) + 16'd1);
    meas(w);
    for (int c = 0; c < 4; c++) begin
      h = (d[c] == 8'h00) ? w : (d[c] == 8'hff) ? 16'h0 : 16'(d[c]) * 16'd2 * (16'(div) + 16'd1);
      if (pol) h = w - h;
      chk(hiCnt[c], h);
      chk(oeCnt[c], (c > 1) ? w : w - h);
    end
    $display("group test div=%0d pol=%0d done", div, pol);
  endtask

  task automatic fifTest(input logic [7:0] p, input logic [7:0] wd, input logic [7:0] div,
                         input logic pol);
    logic [15:0] w;
    logic [15:0] h;
    wr(ADDR_FIFTH_PERIOD, p);
    wr(ADDR_FIFTH_PULSE_WIDTH, wd);
    wr(ADDR_FIFTH_DIVISOR_LOW, div);
    // Inverted runs also use open drain, so both drive types are seen.
    wr(ADDR_MODULATOR_CONTROL, {1'b0, pol, 1'b1, ~pol, 4'h0});
    repeat (200) @(posedge ref_clk);
    w = (16'(p) + 16'd1) * 16'd16 * (16'(div) + 16'd1);
    h = ((wd == 8'h00) ? 16'd1 : 16'(wd)) * 16'd16 * (16'(div) + 16'd1);
    if (pol) h = w - h;
    meas(w);
    chk(hiCnt[4], h);
    chk(oeCnt[4], pol ? w - h : w);
    $display("fifth test period=%0d width=%0d done", p, wd);
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    wrap_up();
  end

  initial begin
    regAddr = '{ADDR_MODULATOR_CONTROL, ADDR_DUTY_CH0, ADDR_DUTY_CH1, ADDR_DUTY_CH2,
                ADDR_DUTY_CH3, ADDR_FIFTH_PERIOD, ADDR_FIFTH_PULSE_WIDTH,
                ADDR_GROUP_DIVISOR_LOW, ADDR_GROUP_DIVISOR_HIGH,
                ADDR_FIFTH_DIVISOR_LOW, ADDR_FIFTH_DIVISOR_HIGH};
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (regAddr[i]) rd(regAddr[i], RESET_REG);
    rd(8'ha6, UNMAPPED_READ);
    foreach (regAddr[i]) begin
      logic [7:0] v;
      v = nextRand();
      wr(regAddr[i], v);
      rd(regAddr[i], v);
    end
    wr(ADDR_GROUP_DIVISOR_HIGH, 8'h00);
    wr(ADDR_FIFTH_DIVISOR_HIGH, 8'h00);
    $display("register test done");
    grpTest(8'h00, 1'b0);
    grpTest(8'h01, 1'b1);
    // Stopping the unit first lets the next start load fresh compares.
    wr(ADDR_MODULATOR_CONTROL, 8'h00);
    fifTest(8'h09, 8'h03, 8'h00, 1'b0);
    fifTest(8'h07, 8'h05, 8'h01, 1'b1);
    wr(ADDR_MODULATOR_CONTROL, 8'h1f);
    repeat (8) @(posedge ref_clk);
    meas(16'd64);
    chk(oeCnt[0] + oeCnt[1] + oeCnt[2] + oeCnt[3] + oeCnt[4], 16'h0);
    $display("disable test done");
    repeat (2) @(posedge ref_clk);
    wrap_up();
  end
endmodule

// ===== verilog/dual_prescaled_pwm_unit.sv
`timescale 1ns/1ps
module dual_prescaled_pwm_unit #(
  parameter int CHANNELS = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire pwm_unit_pkg::bus_req_t busReq,
  output logic [7:0] rdata,
  // Group outputs, open-drain pins use the enable
  output logic [CHANNELS-1:0] groupOut,
  output logic [CHANNELS-1:0] groupOe,
  // Fifth channel output
  output logic fifthOut,
  output logic fifthOe
);
  import pwm_unit_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] controlReg;
  logic [7:0] dutyReg [CHANNELS];
  logic [7:0] fifthPeriodReg;
  logic [7:0] fifthWidthReg;
  logic [15:0] groupDivisorReg;
  logic [15:0] fifthDivisorReg;

  logic groupPolarity;
  logic fifthPolarity;
  logic enable;
  logic fifthDriveType;
  logic [3:0] groupDriveType;
  assign groupPolarity = controlReg[BIT_GROUP_POLARITY];
  assign fifthPolarity = controlReg[BIT_FIFTH_POLARITY];
  assign enable = controlReg[BIT_MODULATOR_ENABLE];
  assign fifthDriveType = controlReg[BIT_FIFTH_DRIVE_TYPE];
  assign groupDriveType = controlReg[BIT_GROUP_DRIVE_LSB +: 4];

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      controlReg <= RESET_REG;
      fifthPeriodReg <= RESET_REG;
      fifthWidthReg <= RESET_REG;
      groupDivisorReg <= {RESET_REG, RESET_REG};
      fifthDivisorReg <= {RESET_REG, RESET_REG};
      for (int i = 0; i < CHANNELS; i++) begin
        dutyReg[i] <= RESET_REG;
      end
    end else if (busReq.wr) begin
      unique case (busReq.addr)
        ADDR_MODULATOR_CONTROL: controlReg <= busReq.wdata;
        ADDR_FIFTH_PERIOD: fifthPeriodReg <= busReq.wdata;
        ADDR_FIFTH_PULSE_WIDTH: fifthWidthReg <= busReq.wdata;
        ADDR_GROUP_DIVISOR_LOW: groupDivisorReg[7:0] <= busReq.wdata;
        ADDR_GROUP_DIVISOR_HIGH: groupDivisorReg[15:8] <= busReq.wdata;
        ADDR_FIFTH_DIVISOR_LOW: fifthDivisorReg[7:0] <= busReq.wdata;
        ADDR_FIFTH_DIVISOR_HIGH: fifthDivisorReg[15:8] <= busReq.wdata;
        default: begin
          for (int i = 0; i < CHANNELS; i++) begin
            if (busReq.addr == ADDR_DUTY_CH0 + 8'(i)) begin
              dutyReg[i] <= busReq.wdata;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read port: data stand one cycle after the strobe, only then.
  // ----------------------------------------------------------------
  logic [7:0] readValue;
  always_comb begin
    readValue = UNMAPPED_READ;
    unique case (busReq.addr)
      ADDR_MODULATOR_CONTROL: readValue = controlReg;
      ADDR_FIFTH_PERIOD: readValue = fifthPeriodReg;
      ADDR_FIFTH_PULSE_WIDTH: readValue = fifthWidthReg;
      ADDR_GROUP_DIVISOR_LOW: readValue = groupDivisorReg[7:0];
      ADDR_GROUP_DIVISOR_HIGH: readValue = groupDivisorReg[15:8];
      ADDR_FIFTH_DIVISOR_LOW: readValue = fifthDivisorReg[7:0];
      ADDR_FIFTH_DIVISOR_HIGH: readValue = fifthDivisorReg[15:8];
      default: begin
        for (int i = 0; i < CHANNELS; i++) begin
          if (busReq.addr == ADDR_DUTY_CH0 + 8'(i)) begin
            readValue = dutyReg[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (busReq.rd) begin
      rdata <= readValue;
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Half-clock tick shared by both prescalers.
  // ----------------------------------------------------------------
  logic halfTick_reg;
  always_ff @(posedge ref_clk) begin
    if (!rstn || !enable) begin
      halfTick_reg <= 1'b0;
    end else begin
      halfTick_reg <= ~halfTick_reg;
    end
  end

  // Prescaler step: returns 1 when the count reaches the divisor.
  function automatic logic divider_done(input logic [15:0] count, input logic [15:0] div);
    return count >= div;
  endfunction

  // Duty 00h and FFh are pinned levels. A plain compare would leave 00h low
  // throughout and let FFh stay high for 255 of the 256 counts.
  function automatic logic duty_level(input logic [7:0] duty, input logic [7:0] count);
    logic level;
    if (duty == 8'h00) begin
      level = 1'b1;
    end else if (duty == 8'hff) begin
      level = 1'b0;
    end else begin
      level = duty > count;
    end
    return level;
  endfunction

  // ----------------------------------------------------------------
  // Group prescaler and counter
  // ----------------------------------------------------------------
  logic [15:0] groupPrescale_reg;
  logic [7:0] groupCount_reg;
  logic groupStep;
  assign groupStep = halfTick_reg && divider_done(groupPrescale_reg, groupDivisorReg);
  always_ff @(posedge ref_clk) begin
    if (!rstn || !enable) begin
      groupPrescale_reg <= 16'h0000;
      groupCount_reg <= 8'h00;
    end else if (halfTick_reg) begin
      if (divider_done(groupPrescale_reg, groupDivisorReg)) begin
        groupPrescale_reg <= 16'h0000;
        groupCount_reg <= groupCount_reg + 8'h01;
      end else begin
        groupPrescale_reg <= groupPrescale_reg + 16'h0001;
      end
    end
  end

  // Polarity-adjusted level of each group channel, one flop ahead of the pin.
  logic [CHANNELS-1:0] groupLevel;
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      groupLevel[i] = duty_level(dutyReg[i], groupCount_reg) ^ groupPolarity;
    end
  end

  // Disabled channels rest at the polarity level with every driver off.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      groupOut <= '0;
      groupOe <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (!enable) begin
          groupOut[i] <= groupPolarity;
        end else begin
          groupOut[i] <= groupLevel[i];
        end
        // Open drain drives only the low level; push-pull drives both.
        groupOe[i] <= enable && (groupDriveType[i % 4] || !groupLevel[i]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Fifth channel
  // ----------------------------------------------------------------
  fifth_state_t fifthState_reg;
  logic [15:0] fifthPrescale_reg;
  logic [15:0] fifthDivActive_reg;
  logic [7:0] fifthCount_reg;
  logic [7:0] widthCompare_reg;
  logic [7:0] periodCompare_reg;
  logic fifthLevel_reg;
  logic fifthStep;
  assign fifthStep = halfTick_reg && divider_done(fifthPrescale_reg, fifthDivActive_reg);

  always_ff @(posedge ref_clk) begin
    if (!rstn || !enable) begin
      fifthState_reg <= FIFTH_IDLE;
      fifthPrescale_reg <= 16'h0000;
      fifthDivActive_reg <= 16'h0000;
      fifthCount_reg <= 8'h00;
      widthCompare_reg <= 8'h00;
      periodCompare_reg <= 8'h00;
      fifthLevel_reg <= 1'b1;
    end else begin
      unique case (fifthState_reg)
        FIFTH_IDLE: begin
          widthCompare_reg <= fifthWidthReg;
          periodCompare_reg <= fifthPeriodReg;
          fifthDivActive_reg <= fifthDivisorReg;
          fifthLevel_reg <= 1'b1;
          fifthState_reg <= FIFTH_RUN;
        end
        FIFTH_RUN: begin
          if (halfTick_reg) begin
            if (fifthStep) begin
              fifthPrescale_reg <= 16'h0000;
            end else begin
              fifthPrescale_reg <= fifthPrescale_reg + 16'h0001;
            end
          end
          if (fifthStep) begin
            if (fifthCount_reg == periodCompare_reg) begin
              fifthCount_reg <= 8'h00;
              fifthLevel_reg <= 1'b1;
              widthCompare_reg <= fifthWidthReg;
              periodCompare_reg <= fifthPeriodReg;
              fifthDivActive_reg <= fifthDivisorReg;
            end else begin
              fifthCount_reg <= fifthCount_reg + 8'h01;
              if (fifthCount_reg + 8'h01 >= widthCompare_reg) begin
                fifthLevel_reg <= 1'b0;
              end
            end
          end
        end
      endcase
    end
  end

  // The period compare relies on software keeping period nonzero.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      fifthOut <= 1'b0;
      fifthOe <= 1'b0;
    end else begin
      fifthOut <= (enable ? fifthLevel_reg : 1'b0) ^ fifthPolarity;
      fifthOe <= enable && (fifthDriveType
                 || !(fifthLevel_reg ^ fifthPolarity));
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Clocks since the last group counter step. A divisor write restarts the
  // gap, since a smaller divisor ends the running prescale at once.
  logic [17:0] groupGap_reg;
  always_ff @(posedge ref_clk) begin
    if (!rstn || !enable) begin
      groupGap_reg <= 18'h00000;
    end else if (groupStep) begin
      groupGap_reg <= 18'h00001;
    end else if (busReq.wr && (busReq.addr == ADDR_GROUP_DIVISOR_LOW
                 || busReq.addr == ADDR_GROUP_DIVISOR_HIGH)) begin
      groupGap_reg <= 18'h00000;
    end else begin
      groupGap_reg <= groupGap_reg + 18'h00001;
    end
  end

  AST_WRAP: assert property (@(posedge ref_clk) disable iff (!rstn)
    (halfTick_reg && groupPrescale_reg >= groupDivisorReg && groupCount_reg == 8'hff
     && enable) |=> groupCount_reg == 8'h00)
    else $error("Group counter did not wrap.");
  AST_HIGH: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && !groupPolarity && dutyReg[2] != 8'hff && dutyReg[2] > groupCount_reg)
    |=> groupOut[2])
    else $error("Channel 2 not high.");
  AST_LOW: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && !groupPolarity && dutyReg[2] != 8'h00 && dutyReg[2] <= groupCount_reg)
    |=> !groupOut[2])
    else $error("Channel 2 not low.");
  AST_ZERO: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && !groupPolarity && dutyReg[0] == 8'h00) |=> groupOut[0])
    else $error("Duty zero not high.");
  AST_FULL: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && !groupPolarity && dutyReg[1] == 8'hff) |=> !groupOut[1])
    else $error("Duty all ones not low.");
  AST_INVERT: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && groupPolarity && dutyReg[2] != 8'hff && dutyReg[2] > groupCount_reg)
    |=> !groupOut[2])
    else $error("Polarity not inverted.");
  AST_GAP: assert property (@(posedge ref_clk) disable iff (!rstn)
    enable |-> groupGap_reg <= {1'b0, groupDivisorReg, 1'b0} + 18'h00002)
    else $error("Group step came too late.");
  AST_OE_DRAIN: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && !groupDriveType[0]) |=> groupOe[0] == !groupOut[0])
    else $error("Open drain channel drove high.");
  AST_OE_PUSH: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && groupDriveType[3]) |=> groupOe[3])
    else $error("Push-pull channel not driven.");
  AST_TICK: assert property (@(posedge ref_clk) disable iff (!rstn)
    halfTick_reg |=> !halfTick_reg)
    else $error("Half tick too fast.");
  AST_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!enable) |=> (groupCount_reg == 8'h00 && fifthCount_reg == 8'h00))
    else $error("Counters not held.");
  AST_OFF_OE: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!enable) |=> (groupOe == '0 && !fifthOe))
    else $error("Disabled unit still drives.");

  // ----------------------------------------------------------------
  // Fifth channel assertions
  // ----------------------------------------------------------------
  AST_PERIOD: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && fifthState_reg == FIFTH_RUN && fifthStep
     && fifthCount_reg == periodCompare_reg) |=> (fifthCount_reg == 8'h00 && fifthLevel_reg))
    else $error("Period end not handled.");
  AST_LOAD: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && fifthState_reg == FIFTH_RUN && !(fifthStep
     && fifthCount_reg == periodCompare_reg)) |=> $stable(periodCompare_reg))
    else $error("Compare changed mid period.");
  AST_ENABLE_LOAD: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && fifthState_reg == FIFTH_IDLE) |=> (periodCompare_reg == $past(fifthPeriodReg)
     && widthCompare_reg == $past(fifthWidthReg)))
    else $error("Compares not loaded at enable.");
  AST_FIFTH_LOW: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && fifthState_reg == FIFTH_RUN && fifthCount_reg != 8'h00
     && fifthCount_reg >= widthCompare_reg) |-> !fifthLevel_reg)
    else $error("Fifth level high past width.");
  AST_FIFTH_HIGH: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && fifthState_reg == FIFTH_RUN && fifthCount_reg < widthCompare_reg) |-> fifthLevel_reg)
    else $error("Fifth level low inside width.");
  AST_FIFTH_STEP: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && fifthState_reg == FIFTH_RUN && fifthStep && fifthCount_reg != periodCompare_reg)
    |=> fifthCount_reg == $past(fifthCount_reg) + 8'h01)
    else $error("Fifth counter did not advance.");
  AST_FAST: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && fifthState_reg == FIFTH_RUN && fifthDivActive_reg == 16'h0000 && halfTick_reg)
    |=> (fifthCount_reg != $past(fifthCount_reg) || fifthCount_reg == 8'h00))
    else $error("Divisor zero did not step every tick.");
  AST_FIFTH_DRAIN: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && !fifthDriveType) |=> fifthOe == !fifthOut)
    else $error("Fifth open drain drove high.");
  AST_FIFTH_PUSH: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && fifthDriveType) |=> fifthOe)
    else $error("Fifth push-pull not driven.");
  AST_FIFTH_POL: assert property (@(posedge ref_clk) disable iff (!rstn)
    (enable && fifthPolarity) |=> fifthOut != $past(fifthLevel_reg))
    else $error("Fifth polarity not inverted.");
  AST_FIFTH_OFF: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!enable) |=> (fifthState_reg == FIFTH_IDLE && fifthPrescale_reg == 16'h0000
     && groupPrescale_reg == 16'h0000))
    else $error("Prescalers not held.");

  COV_WRAP: cover property (@(posedge ref_clk) groupCount_reg == 8'hff ##1 groupCount_reg == 8'h00);
  COV_PERIOD: cover property (@(posedge ref_clk) fifthStep && fifthCount_reg == periodCompare_reg);
  COV_FIFTH_LOW: cover property (@(posedge ref_clk) $fell(fifthLevel_reg));
  COV_INVERT: cover property (@(posedge ref_clk) enable && groupPolarity);
  COV_ENABLE_LOAD: cover property (@(posedge ref_clk) enable && fifthState_reg == FIFTH_IDLE);

endmodule
